// ==== hdl/ext_int_pkg.sv ====
// Overview of operation
// RULE1 - pin activity interrupts even when pins drive outputs
// RULE2 - upper bank request on enabled pins 15..8 toggling
// RULE3 - lower bank request on enabled pins 7..0 toggling
// RULE4 - per-bank masks select contributing change pins
// RULE5 - pin-change detection needs no I/O clock (here the change term of o_wake is synchronised and registered on i_clock)
// RULE6 - low-level request held while pin stays low
// RULE7 - edge recognition runs on the I/O clock
// RULE8 - low-level detection works asynchronously for wake (here the level term of o_wake is synchronised and registered on i_clock)
// RULE9 - wake level must last through start-up time
// RULE10 - line taken only with global and line enable
// RULE11 - pin sampled first; pulses over one clock caught (here a level counts only once stages two and three agree on it)
// RULE12 - level must hold until current instruction ends
// RULE13 - sense 00 low, 01 change, 10 fall, 11 rise
// RULE14 - sense bits line1 3:2, line0 1:0, 7:4 zero
// RULE15 - vectors two words apart: 0, 2, 4, 6
// RULE16 - each line enabled by its own mask bit
// RULE17 - flag set on trigger, cleared by vector or write-one
// RULE18 - line flag reads zero in low-level mode
// RULE19 - upper pin needs its mask and bank enable
// RULE20 - two-stage synchroniser before edge compare (here three stages per pin; edges are judged once stages two and three agree)
// RULE21 - lowest vector address served first
package ext_int_pkg;
  // register byte addresses
  localparam logic [4:0] SENSE_CTRL_OFFS  = 5'h00;
  localparam logic [4:0] LINE_ENABLE_OFFS = 5'h04;
  localparam logic [4:0] LINE_FLAG_OFFS   = 5'h08;
  localparam logic [4:0] BANK_ENABLE_OFFS = 5'h0C;
  localparam logic [4:0] BANK_FLAG_OFFS   = 5'h10;
  localparam logic [4:0] UPPER_MASK_OFFS  = 5'h14;
  localparam logic [4:0] LOWER_MASK_OFFS  = 5'h18;
  // field positions and resets
  localparam int LINE0_SENSE_POS = 0;
  localparam int LINE1_SENSE_POS = 2;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] LINE_IDLE = 2'h3;  // dedicated lines rest high
  // vector addresses
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_LINE0 = 16'h0002;
  localparam logic [15:0] VEC_LINE1 = 16'h0004;
  localparam logic [15:0] VEC_LOWER = 16'h0006;
  localparam logic [15:0] VEC_UPPER = 16'h0008;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SENSE_LOW, SENSE_CHANGE, SENSE_FALL, SENSE_RISE
  } sense_mode_t;

  // vectoring request/answer
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } vector_req_t;
endpackage : ext_int_pkg

// ==== hdl/external_pin_interrupt_unit.sv ====
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module external_pin_interrupt_unit
  import ext_int_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic              i_resetn,
  input  wire logic [1:0]        i_ext_lines,
  input  wire logic [15:0]       i_change_inputs,
  input  wire logic              i_global_int_enable,
  input  wire logic              i_vector_ack,
  output vector_req_t            o_vector,
  output logic                   o_wake,
  input  wire logic [4:0]        i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [4:0]        i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready
);
  // registers
  logic [3:0]  sense_ctrl_reg;
  logic [1:0]  line_enable_reg;
  logic [1:0]  line_flag_reg;
  logic [1:0]  bank_enable_reg;
  logic [1:0]  bank_flag_reg;
  logic [7:0]  upper_bank_mask;
  logic [7:0]  lower_bank_mask;
  // synchronisers, three stages per pin
  logic [1:0]  line_s1_reg, line_s2_reg, line_s3_reg;
  logic [15:0] chg_s1_reg, chg_s2_reg, chg_s3_reg;
  // level last agreed by stages two and three; edges are judged against it
  logic [1:0]  line_lvl_reg, line_rise, line_fall;
  logic [15:0] chg_lvl_reg;
  // write channel capture
  logic        aw_hold_reg, w_hold_reg;
  logic [4:0]  aw_addr_reg;
  logic [7:0]  w_data_reg;
  logic        w_lane0_reg;
  logic        wr_fire;
  logic [1:0]  line_trig, line_low, line_clr, line_active;
  logic [15:0] chg_trig;
  logic        upper_trig, lower_trig;
  logic [1:0]  bank_clr;
  logic        lower_req, upper_req;

  function automatic logic [1:0] sense_of(input logic [3:0] ctrl, input int n);
    sense_of = (n == 0) ? ctrl[LINE0_SENSE_POS +: 2] : ctrl[LINE1_SENSE_POS +: 2];
  endfunction : sense_of

  // three flops; second and third must agree, first is read only by second
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      // lines reset to their idle level so release gives no false edge
      line_s1_reg  <= LINE_IDLE;
      line_s2_reg  <= LINE_IDLE;
      line_s3_reg  <= LINE_IDLE;
      line_lvl_reg <= LINE_IDLE;
      chg_s1_reg   <= 16'h0000;
      chg_s2_reg   <= 16'h0000;
      chg_s3_reg   <= 16'h0000;
      chg_lvl_reg  <= 16'h0000;
    end else begin
      line_s1_reg <= i_ext_lines;      // RULE11 RULE20 RULE1
      line_s2_reg <= line_s1_reg;
      line_s3_reg <= line_s2_reg;
      chg_s1_reg  <= i_change_inputs;  // RULE1
      chg_s2_reg  <= chg_s1_reg;
      chg_s3_reg  <= chg_s2_reg;
      // a new level counts only once stages two and three agree on it
      line_lvl_reg <= (line_s2_reg & line_s3_reg) | (line_lvl_reg & (line_s2_reg | line_s3_reg));
      chg_lvl_reg  <= (chg_s2_reg & chg_s3_reg) | (chg_lvl_reg & (chg_s2_reg | chg_s3_reg));
    end
  end

  // agreed edges per dedicated line
  assign line_rise = line_s2_reg & line_s3_reg & ~line_lvl_reg;
  assign line_fall = ~line_s2_reg & ~line_s3_reg & line_lvl_reg;

  // edge and level decode per dedicated line
  always_comb begin
    for (int n = 0; n < 2; n++) begin
      line_low[n] = ~line_s2_reg[n] & ~line_s3_reg[n];  // RULE6 RULE12
      case (sense_mode_t'(sense_of(sense_ctrl_reg, n)))  // RULE13
        SENSE_LOW:    line_trig[n] = 1'b0;
        SENSE_CHANGE: line_trig[n] = line_rise[n] | line_fall[n];   // RULE7
        SENSE_FALL:   line_trig[n] = line_fall[n];
        SENSE_RISE:   line_trig[n] = line_rise[n];
        default:      line_trig[n] = 1'b0;
      endcase
    end
  end

  // pin changes masked per bank
  assign chg_trig   = (chg_s2_reg & chg_s3_reg & ~chg_lvl_reg)
                    | (~chg_s2_reg & ~chg_s3_reg & chg_lvl_reg);
  assign upper_trig = |(chg_trig[15:8] & upper_bank_mask);  // RULE2 RULE4 RULE19
  assign lower_trig = |(chg_trig[7:0] & lower_bank_mask);   // RULE3 RULE4

  // a line is active when latched or, in level mode, while held low
  always_comb begin
    for (int n = 0; n < 2; n++) begin
      if (sense_of(sense_ctrl_reg, n) == SENSE_LOW) begin
        line_active[n] = line_low[n];                        // RULE6
      end else begin
        line_active[n] = line_flag_reg[n];
      end
    end
  end

  // enables gate every request
  assign lower_req = bank_flag_reg[0] & bank_enable_reg[0];
  assign upper_req = bank_flag_reg[1] & bank_enable_reg[1];  // RULE19

  // vector acknowledge clears only the served source
  always_comb begin
    line_clr = 2'h0;
    bank_clr = 2'h0;
    if (i_vector_ack && o_vector.valid) begin
      line_clr[0] = (o_vector.addr == VEC_LINE0);            // RULE17
      line_clr[1] = (o_vector.addr == VEC_LINE1);
      bank_clr[0] = (o_vector.addr == VEC_LOWER);
      bank_clr[1] = (o_vector.addr == VEC_UPPER);
    end
    if (wr_fire && w_lane0_reg && aw_addr_reg == LINE_FLAG_OFFS) begin
      line_clr = line_clr | w_data_reg[1:0];                 // RULE17
    end
    if (wr_fire && w_lane0_reg && aw_addr_reg == BANK_FLAG_OFFS) begin
      bank_clr = bank_clr | w_data_reg[1:0];
    end
  end

  // sticky flags; a new trigger wins over a clear
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      line_flag_reg <= 2'h0;
      bank_flag_reg <= 2'h0;
    end else begin
      for (int n = 0; n < 2; n++) begin
        if (sense_of(sense_ctrl_reg, n) == SENSE_LOW) begin
          line_flag_reg[n] <= 1'b0;                          // RULE18
        end else if (line_trig[n]) begin
          line_flag_reg[n] <= 1'b1;                          // RULE17
        end else if (line_clr[n]) begin
          line_flag_reg[n] <= 1'b0;
        end
      end
      bank_flag_reg[0] <= lower_trig | (bank_flag_reg[0] & ~bank_clr[0]);
      bank_flag_reg[1] <= upper_trig | (bank_flag_reg[1] & ~bank_clr[1]);
    end
  end

  // fixed-priority vector select, lowest address first
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_vector <= '{valid: 1'b0, addr: VEC_RESET};
    end else if (!i_global_int_enable) begin
      o_vector <= '{valid: 1'b0, addr: VEC_RESET};           // RULE10
    end else if (line_active[0] && line_enable_reg[0]) begin
      o_vector <= '{valid: 1'b1, addr: VEC_LINE0};           // RULE21 RULE15 RULE16
    end else if (line_active[1] && line_enable_reg[1]) begin
      o_vector <= '{valid: 1'b1, addr: VEC_LINE1};           // RULE16
    end else if (lower_req) begin
      o_vector <= '{valid: 1'b1, addr: VEC_LOWER};
    end else if (upper_req) begin
      o_vector <= '{valid: 1'b1, addr: VEC_UPPER};
    end else begin
      o_vector <= '{valid: 1'b0, addr: VEC_RESET};
    end
  end

  // wake: synchronised level and change terms, registered to keep outputs
  // flop-driven; the sleep controller should use the same terms unclocked
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_wake <= 1'b0;
    end else begin
      o_wake <= |(line_low & line_enable_reg & {sense_ctrl_reg[3:2] == 2'h0,
                sense_ctrl_reg[1:0] == 2'h0})                 // RULE8 RULE9
              | (|(chg_trig[15:8] & upper_bank_mask) & bank_enable_reg[1])
              | (|(chg_trig[7:0] & lower_bank_mask) & bank_enable_reg[0]); // RULE5
    end
  end

  // axi write: address and data accepted in either order
  assign wr_fire = aw_hold_reg & w_hold_reg & ~o_bvalid;

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_addr_reg <= 5'h00;
      w_data_reg  <= 8'h00;
      w_lane0_reg <= 1'b0;
      o_awready   <= 1'b0;
      o_wready    <= 1'b0;
      o_bvalid    <= 1'b0;
      o_bresp     <= AXI_OKAY;
    end else begin
      o_awready <= ~aw_hold_reg & ~(i_awvalid & o_awready);
      o_wready  <= ~w_hold_reg & ~(i_wvalid & o_wready);
      if (i_awvalid && o_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_hold_reg  <= 1'b1;
        w_data_reg  <= i_wdata[7:0];
        w_lane0_reg <= i_wstrb[0];
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        o_bvalid    <= 1'b1;
        o_bresp     <= (aw_addr_reg[1:0] == 2'h0 && aw_addr_reg <= LOWER_MASK_OFFS)
                       ? AXI_OKAY : AXI_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // control registers, lane 0 only carries data
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      sense_ctrl_reg  <= REG_RESET[3:0];
      line_enable_reg <= REG_RESET[1:0];
      bank_enable_reg <= REG_RESET[1:0];
      upper_bank_mask <= REG_RESET;
      lower_bank_mask <= REG_RESET;
    end else if (wr_fire && w_lane0_reg) begin
      case (aw_addr_reg)
        SENSE_CTRL_OFFS:  sense_ctrl_reg  <= w_data_reg[3:0];  // RULE14
        LINE_ENABLE_OFFS: line_enable_reg <= w_data_reg[1:0];
        BANK_ENABLE_OFFS: bank_enable_reg <= w_data_reg[1:0];
        UPPER_MASK_OFFS:  upper_bank_mask <= w_data_reg;
        LOWER_MASK_OFFS:  lower_bank_mask <= w_data_reg;
        default:          ;
      endcase
    end
  end

  // axi read, one outstanding
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= AXI_OKAY;
    end else begin
      o_arready <= ~o_rvalid & ~(i_arvalid & o_arready);
      if (i_arvalid && o_arready) begin
        o_rvalid <= 1'b1;
        o_rresp  <= AXI_OKAY;
        case (i_araddr)
          SENSE_CTRL_OFFS:  o_rdata <= {28'h0, sense_ctrl_reg};  // RULE14
          LINE_ENABLE_OFFS: o_rdata <= {30'h0, line_enable_reg};
          LINE_FLAG_OFFS:   o_rdata <= {30'h0, line_flag_reg};
          BANK_ENABLE_OFFS: o_rdata <= {30'h0, bank_enable_reg};
          BANK_FLAG_OFFS:   o_rdata <= {30'h0, bank_flag_reg};
          UPPER_MASK_OFFS:  o_rdata <= {24'h0, upper_bank_mask};
          LOWER_MASK_OFFS:  o_rdata <= {24'h0, lower_bank_mask};
          default: begin
            o_rdata <= 32'h0000_0000;
            o_rresp <= AXI_SLVERR;
          end
        endcase
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // assertions
  sequence s_fall0;
    line_fall[0] && sense_ctrl_reg[1:0] == 2'h2;
  endsequence

  a_level_flag_zero: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE18
    sense_ctrl_reg[1:0] == 2'h0 |=> !line_flag_reg[0] || sense_ctrl_reg[1:0] != 2'h0)
    else $error("line0 flag set in level mode");
  a_fall_sets_flag: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE17
    s_fall0 ##1 sense_ctrl_reg[1:0] == 2'h2 |-> line_flag_reg[0])
    else $error("falling edge lost");
  a_global_gate: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE10
    !i_global_int_enable |=> !o_vector.valid)
    else $error("vector with global flag off");
  a_line0_prio: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE21
    i_global_int_enable && line_active[0] && line_enable_reg[0]
    |=> o_vector.valid && o_vector.addr == 16'h0002)
    else $error("line0 not first");
  a_lower_bank: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE3
    |(chg_trig[7:0] & lower_bank_mask) |=> bank_flag_reg[0])
    else $error("lower change missed");
  a_upper_mask: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE4
    $rose(bank_flag_reg[1]) |-> $past(|(chg_trig[15:8] & upper_bank_mask)))
    else $error("masked pin set flag");
  a_level_req: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE6
    i_global_int_enable && sense_ctrl_reg[1:0] == 2'h0 && line_enable_reg[0]
    && line_low[0] |=> o_vector.valid && o_vector.addr == 16'h0002)
    else $error("held low without request");
  a_sense_rsvd: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE14
    o_rvalid && $past(i_araddr) == 5'h00 && $past(i_arvalid && o_arready)
    |-> o_rdata[31:4] == 28'h0)
    else $error("reserved sense bits nonzero");
  a_upper_bank: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE2
    |(chg_trig[15:8] & upper_bank_mask) |=> bank_flag_reg[1])
    else $error("upper change missed");
endmodule : external_pin_interrupt_unit

// ==== sim/pin_model.sv ====
`timescale 1ns/1ps
// board side of the pins: lines idle high, change pins idle low
module pin_model (
  input  wire logic        i_clock,
  output logic [1:0]       o_ext_lines,
  output logic [15:0]      o_change_inputs
);
  initial begin
    o_ext_lines     = 2'h3;
    o_change_inputs = 16'h0000;
  end

  // new levels launched just after an edge, then held for hold cycles
  // so that no pulse is shorter than the sampling can resolve
  task automatic drive(input logic [1:0] l, input logic [15:0] c, input int hold);
    @(posedge i_clock);
    o_ext_lines     <= l;
    o_change_inputs <= c;
    repeat (hold) @(posedge i_clock);
  endtask : drive
endmodule : pin_model

// ==== sim/tb.sv ====
`timescale 1ns/1ps
module tb;
  import ext_int_pkg::*;
  logic        i_clock = 1'b0;
  logic        i_resetn = 1'b0;
  logic        global_en = 1'b0;
  logic        vector_ack = 1'b0;
  logic [4:0]  awaddr = 5'h00;
  logic [4:0]  araddr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [3:0]  wstrb = 4'hF;
  logic        awready, wready, bvalid, arready, rvalid, wake;
  logic [1:0]  bresp, rresp, lines;
  logic [15:0] change;
  logic [31:0] rdata, d;
  logic [1:0]  r;
  vector_req_t vec;
  int          n_errors = 0;
  int          tests_run = 0;
  logic [15:0] order [4];

  always #25 i_clock = ~i_clock;

  pin_model i_pins (.i_clock(i_clock), .o_ext_lines(lines), .o_change_inputs(change));

  external_pin_interrupt_unit i_dut (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_ext_lines(lines),
    .i_change_inputs(change), .i_global_int_enable(global_en),
    .i_vector_ack(vector_ack), .o_vector(vec), .o_wake(wake),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));

  task automatic end_sim();
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask : chk

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge i_clock);
    awaddr  <= a;
    wdata   <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge i_clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 32'(AXI_OKAY), 32'(bresp));
  endtask : wr

  task automatic rd(input logic [4:0] a);
    @(posedge i_clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge i_clock);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  // one-cycle acknowledge, then let the cleared flag reach o_vector
  task automatic ack();
    @(posedge i_clock);
    vector_ack <= 1'b1;
    @(posedge i_clock);
    vector_ack <= 1'b0;
    repeat (3) @(posedge i_clock);
  endtask : ack

  // a hang ends the run like a failed check
  initial begin
    repeat (20000) @(posedge i_clock);
    n_errors++;
    end_sim();
  end

  initial begin
    order = '{VEC_LINE0, VEC_LINE1, VEC_LOWER, VEC_UPPER};
    repeat (3) @(posedge i_clock);
    i_resetn <= 1'b1;
    rd(SENSE_CTRL_OFFS);
    chk("sense reset", 32'h0, d);
    wr(SENSE_CTRL_OFFS, 8'hFF);
    rd(SENSE_CTRL_OFFS);
    chk("sense reserved", 32'h0000000F, d);
    rd(5'h1C);
    chk("unmapped resp", 32'(AXI_SLVERR), 32'(r));
    // every edge mode on line 1, global flag off so only flags move
    wr(LINE_ENABLE_OFFS, 8'h02);
    for (int m = 1; m < 4; m++) begin
      wr(SENSE_CTRL_OFFS, 8'(m << LINE1_SENSE_POS));
      wr(LINE_FLAG_OFFS, 8'h03);
      i_pins.drive(2'h1, 16'h0, 8);
      rd(LINE_FLAG_OFFS);
      chk("fall flag", {30'h0, m != 3, 1'b0}, d);
      wr(LINE_FLAG_OFFS, 8'h02);
      rd(LINE_FLAG_OFFS);
      chk("w1c flag", 32'h0, d);
      i_pins.drive(2'h3, 16'h0, 8);
      rd(LINE_FLAG_OFFS);
      chk("rise flag", {30'h0, m != 2, 1'b0}, d);
      chk("masked global", 32'h0, 32'(vec.valid));
      wr(LINE_FLAG_OFFS, 8'h02);
    end
    // falling edge on line 0 taken through its vector
    wr(SENSE_CTRL_OFFS, 8'h02);
    wr(LINE_ENABLE_OFFS, 8'h03);
    global_en <= 1'b1;
    i_pins.drive(2'h2, 16'h0, 8);
    chk("line0 vector", {15'h0, 1'b1, VEC_LINE0}, 32'(vec));
    ack();
    rd(LINE_FLAG_OFFS);
    chk("ack clears", 32'h0, d);
    // low level on line 0: request and wake while held, no flag
    wr(SENSE_CTRL_OFFS, 8'h00);
    i_pins.drive(2'h2, 16'h0, 8);
    chk("level vector", {15'h0, 1'b1, VEC_LINE0}, 32'(vec));
    chk("level wake", 32'h1, 32'(wake));
    rd(LINE_FLAG_OFFS);
    chk("level flag", 32'h0, d);
    i_pins.drive(2'h3, 16'h0, 8);
    chk("level gone", 32'h0, 32'(vec.valid));
    // all four sources pending at once, served lowest vector first
    global_en <= 1'b0;
    wr(SENSE_CTRL_OFFS, 8'h0A);
    wr(UPPER_MASK_OFFS, 8'h08);
    wr(LOWER_MASK_OFFS, 8'h01);
    wr(BANK_ENABLE_OFFS, 8'h03);
    i_pins.drive(2'h0, 16'h0801, 8);
    rd(BANK_FLAG_OFFS);
    chk("bank flags", 32'h3, d);
    global_en <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      repeat (2) @(posedge i_clock);
      chk("priority", {15'h0, 1'b1, order[k]}, 32'(vec));
      ack();
    end
    // masked pin 12 toggles: nothing
    i_pins.drive(2'h3, 16'h1801, 8);
    rd(BANK_FLAG_OFFS);
    chk("masked pin", 32'h0, d);
    // a write with lane 0 off must leave the mask alone
    wstrb <= 4'h0;
    wr(UPPER_MASK_OFFS, 8'hFF);
    wstrb <= 4'hF;
    rd(UPPER_MASK_OFFS);
    chk("strobe off", 32'h08, d);
    // upper bank disabled: pin 11 may not raise a request
    wr(BANK_ENABLE_OFFS, 8'h01);
    i_pins.drive(2'h3, 16'h1001, 8);
    chk("bank off", 32'h0, 32'(vec.valid));
    rd(BANK_FLAG_OFFS);
    chk("bank off flag", 32'h2, d);
    end_sim();
  end
endmodule : tb
